/* core_pipe.sv */
`timescale 1ns/10ps
module core_pipe (
   // Clock and watch result
   input  wire logic   clk,
   input  wire logic   watch_exc,
   // Event pulses {commit, error, miss, exl clear, erl clear}
   output logic [4:0]  kind,
   output logic [4:0]  code,
   output logic [63:0] pc,
   output logic [63:0] prev_pc,
   output logic        in_slot,
   output logic        isa16,
   // Data access {valid, store, aborted}
   output logic [2:0]  acc,
   output logic [31:0] paddr
);
   initial begin
      {kind, code, pc, prev_pc, in_slot, isa16, acc, paddr} = '0;
   end

   ////////////////////////////////////////////////////////////
   // PC payload is scrambled after the pulse so stale addresses never help
   task automatic pulse(input logic [4:0] k, input logic [4:0] c, input logic [63:0] p,
                        input logic [63:0] q, input logic s, input logic i);
      @(posedge clk);
      kind <= k;
      code <= c;
      pc <= p;
      prev_pc <= q;
      in_slot <= s;
      isa16 <= i;
      @(posedge clk);
      kind <= 5'h00;
      pc <= ~p;
      prev_pc <= ~q;
   endtask : pulse

   ////////////////////////////////////////////////////////////
   // One-cycle access, hit sampled mid-cycle
   task automatic access(input logic [31:0] a, input logic [2:0] f, output logic h);
      @(posedge clk);
      acc <= f;
      paddr <= a;
      @(negedge clk);
      h = watch_exc;
      @(posedge clk);
      acc <= 3'h0;
      paddr <= ~a;
   endtask : access
endmodule : core_pipe

/* cp0_exc_pkg.sv */
// Functional notes
// RL1 - Timer pending bit set on count match
// RL2 - Pending bits 6:2 follow interrupt inputs
// RL3 - Software sets/clears pending 1:0 only
// RL4 - Exception loads resume_pc with fault address
// RL5 - Delay slot stores branch address, sets flag
// RL6 - Compressed mode: bit 0 holds ISA flag
// RL7 - Extend prefix or jump slot: preceding address
// RL8 - Format chosen from strap after reset
// RL9 - Exception sets level; level blocks resume_pc update
// RL10 - Watch match raises cause code 23
// RL11 - Watch compares physical bits 31:3
// RL12 - Load/store enables gate watch matches
// RL13 - Software initialises watch registers first
// RL14 - Miss writes VA 39:11 to field 32:4
// RL15 - Space type from VA bits 63:62
// RL16 - Page table base left to software
// RL17 - Reserved fields read as zero
// RL18 - Parity register: plain 8-bit storage
// RL19 - Cache error register: plain storage
// RL20 - Error events capture restart PC
// RL21 - Error level freezes error_resume_pc
// RL22 - No delay flag for error PC
// RL23 - delay_slot_flag is cause bit 31
// RL24 - Cold reset sets error level, bootstrap bit
// RL25 - Hardware update beats same-cycle software write (a software write of count_reg replaces that cycle's increment)
// RL26 - Aborted accesses do not watch-match
package cp0_exc_pkg;
   // Register byte addresses
   localparam logic [7:0] ADDR_CAUSE       = 8'h00;
   localparam logic [7:0] ADDR_RESUME_LO   = 8'h04;
   localparam logic [7:0] ADDR_RESUME_HI   = 8'h08;
   localparam logic [7:0] ADDR_WATCH_LO    = 8'h0C;
   localparam logic [7:0] ADDR_WATCH_HI    = 8'h10;
   localparam logic [7:0] ADDR_XCTX_LO     = 8'h14;
   localparam logic [7:0] ADDR_XCTX_HI     = 8'h18;
   localparam logic [7:0] ADDR_PARITY      = 8'h1C;
   localparam logic [7:0] ADDR_CACHE_ERR   = 8'h20;
   localparam logic [7:0] ADDR_ERR_LO      = 8'h24;
   localparam logic [7:0] ADDR_ERR_HI      = 8'h28;
   localparam logic [7:0] ADDR_STATUS      = 8'h2C;
   localparam logic [7:0] ADDR_COUNT       = 8'h30;
   localparam logic [7:0] ADDR_COMPARE     = 8'h34;
   // Field positions
   localparam int CAUSE_BD_BIT    = 31;
   localparam int CAUSE_CODE_LSB  = 2;
   localparam int CAUSE_IP_LSB    = 8;
   localparam int STAT_EXL_BIT    = 1;
   localparam int STAT_ERL_BIT    = 2;
   localparam int STAT_BEV_BIT    = 22;
   localparam int WATCH_W_BIT     = 0;
   localparam int WATCH_R_BIT     = 1;
   localparam logic [4:0] CODE_WATCH = 5'h17;
   localparam logic [1:0] SW_IP_MASK = 2'h3;
   localparam logic [7:0] PARITY_MASK_W = 8'hFF;
   // Response codes
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_RESP = 2'b01
   } bus_state_t;
endpackage : cp0_exc_pkg

/* cp0_exception_state_regs.sv */
`timescale 1ns/10ps
module cp0_exception_state_regs
   import cp0_exc_pkg::*;
(
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        RST_N,
   // Strap
   input  wire logic        COMPRESSED_ISA_ENABLE,
   // Interrupt sources
   input  wire logic [4:0]  INT_REQ,
   // Exception commit
   input  wire logic        EXC_COMMIT,
   input  wire logic [4:0]  EXC_CODE,
   input  wire logic [63:0] EXC_PC,
   input  wire logic [63:0] EXC_PREV_PC,
   input  wire logic        EXC_IN_SLOT,
   input  wire logic        EXC_ISA16,
   input  wire logic        EXC_MODE64,
   // Translation miss
   input  wire logic        TLB_MISS,
   input  wire logic [63:0] MISS_VADDR,
   // Error events and level clears
   input  wire logic        ERR_EVENT,
   input  wire logic        ERR_CLEAR,
   input  wire logic        EXL_CLEAR,
   // Data access
   input  wire logic        ACC_VALID,
   input  wire logic        ACC_STORE,
   input  wire logic        ACC_ABORTED,
   input  wire logic [31:0] ACC_PADDR,
   // Status outputs
   output logic             WATCH_EXC,
   output logic [7:0]       INT_PENDING,
   output logic             EXCEPTION_LEVEL,
   output logic             ERROR_LEVEL,
   output logic             BOOTSTRAP_VECTOR_SELECT,
   // AXI4-Lite slave
   input  wire logic [7:0]  S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   output logic [1:0]       S_AXI_BRESP,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   input  wire logic [7:0]  S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   output logic [31:0]      S_AXI_RDATA,
   output logic [1:0]       S_AXI_RRESP,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY
);
   ////////////////////////////////////////////////////////////////////////////////
   logic             isa16_reg;
   logic             strap_done_reg;
   logic [1:0]       sw_ip_reg;
   logic             timer_ip_reg;
   logic             bd_reg;
   logic [4:0]       code_reg;
   logic [63:0]      resume_reg;
   logic [63:0]      err_resume_reg;
   logic             exl_reg;
   logic             erl_reg;
   logic             bev_reg;
   logic [31:0]      watch_lo_reg;
   logic [31:0]      watch_hi_reg;
   logic [28:0]      ptbase_reg;
   logic [1:0]       space_reg;
   logic [28:0]      vpn2_reg;
   logic [7:0]       parity_reg;
   logic [31:0]      cache_err_reg;
   logic [31:0]      count_reg;
   logic [31:0]      compare_reg;
   logic             watch_hit;
   logic             aw_full_reg;
   logic             w_full_reg;
   logic [7:0]       aw_addr_reg;
   logic [31:0]      w_data_reg;
   logic [3:0]       w_strb_reg;
   logic             bvalid_reg;
   logic [1:0]       bresp_reg;
   logic             rvalid_reg;
   logic [31:0]      rdata_reg;
   logic [1:0]       rresp_reg;
   logic             wr_go;
   logic             resume_upd;
   logic [63:0]      ret_addr;
   logic [31:0]      xctx_hi_wr;

   // Byte-lane merge of a 32-bit word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            r[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   // Return address with optional mode bit in bit 0
   function automatic logic [63:0] ret_fmt(input logic [63:0] pc, input logic isa16,
                                           input logic en16, input logic m64);
      logic [63:0] r;
      r = m64 ? pc : {{32{pc[31]}}, pc[31:0]};
      if (en16) begin
         r[0] = isa16;  // [RL6]
      end
      return r;
   endfunction : ret_fmt

   ////////////////////////////////////////////////////////////////////////////////
   // AXI write and read channels
   assign S_AXI_AWREADY = !aw_full_reg && !bvalid_reg;
   assign S_AXI_WREADY  = !w_full_reg && !bvalid_reg;
   assign S_AXI_BVALID  = bvalid_reg;
   assign S_AXI_BRESP   = bresp_reg;
   assign S_AXI_ARREADY = !rvalid_reg;
   assign S_AXI_RVALID  = rvalid_reg;
   assign S_AXI_RDATA   = rdata_reg;
   assign S_AXI_RRESP   = rresp_reg;
   assign wr_go = aw_full_reg && w_full_reg && !bvalid_reg;

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         aw_full_reg <= 1'b0;
         w_full_reg  <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg  <= 32'h0000_0000;
         w_strb_reg  <= 4'h0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= RESP_OKAY;
      end else begin
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_full_reg <= 1'b1;
            w_data_reg <= S_AXI_WDATA;
            w_strb_reg <= S_AXI_WSTRB;
         end
         if (wr_go) begin
            aw_full_reg <= 1'b0;
            w_full_reg  <= 1'b0;
            bvalid_reg  <= 1'b1;
            bresp_reg   <= (aw_addr_reg > ADDR_COMPARE || aw_addr_reg[1:0] != 2'h0)
                           ? RESP_SLVERR : RESP_OKAY;
         end else if (bvalid_reg && S_AXI_BREADY) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read mux; reserved bits come back zero
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h0000_0000;
         rresp_reg  <= RESP_OKAY;
      end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         rvalid_reg <= 1'b1;
         rresp_reg  <= RESP_OKAY;
         unique case (S_AXI_ARADDR)
            ADDR_CAUSE:     rdata_reg <= {bd_reg, 15'h0000, INT_PENDING, 1'b0,
                                          code_reg, 2'h0};  // [RL17] [RL23]
            ADDR_RESUME_LO: rdata_reg <= resume_reg[31:0];
            ADDR_RESUME_HI: rdata_reg <= resume_reg[63:32];
            ADDR_WATCH_LO:  rdata_reg <= {watch_lo_reg[31:3], 1'b0,
                                          watch_lo_reg[1:0]};  // [RL17]
            ADDR_WATCH_HI:  rdata_reg <= watch_hi_reg;
            ADDR_XCTX_LO:   rdata_reg <= {vpn2_reg[27:0], 4'h0};  // [RL17]
            ADDR_XCTX_HI:   rdata_reg <= {ptbase_reg, space_reg, vpn2_reg[28]};
            ADDR_PARITY:    rdata_reg <= {24'h000000, parity_reg};  // [RL17]
            ADDR_CACHE_ERR: rdata_reg <= cache_err_reg;
            ADDR_ERR_LO:    rdata_reg <= err_resume_reg[31:0];
            ADDR_ERR_HI:    rdata_reg <= err_resume_reg[63:32];
            ADDR_STATUS:    rdata_reg <= {9'h000, bev_reg, 19'h00000, erl_reg,
                                          exl_reg, isa16_reg};
            ADDR_COUNT:     rdata_reg <= count_reg;
            ADDR_COMPARE:   rdata_reg <= compare_reg;
            default: begin
               rdata_reg <= 32'h0000_0000;
               rresp_reg <= RESP_SLVERR;
            end
         endcase
      end else if (rvalid_reg && S_AXI_RREADY) begin
         rvalid_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Strap caught by a clocked process after reset release
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         strap_done_reg <= 1'b0;
         isa16_reg      <= 1'b0;
      end else if (!strap_done_reg) begin
         strap_done_reg <= 1'b1;
         isa16_reg      <= COMPRESSED_ISA_ENABLE;  // [RL8]
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt pending
   assign INT_PENDING = {timer_ip_reg, INT_REQ, sw_ip_reg};  // [RL2]

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         count_reg    <= 32'h0000_0000;
         compare_reg  <= 32'hFFFF_FFFF;
         timer_ip_reg <= 1'b0;
      end else begin
         count_reg <= count_reg + 32'h0000_0001;
         if (wr_go && aw_addr_reg == ADDR_COUNT) begin
            count_reg <= merge(count_reg, w_data_reg, w_strb_reg);
         end
         // Writing compare acknowledges the timer; a match in the same cycle wins
         if (wr_go && aw_addr_reg == ADDR_COMPARE) begin
            compare_reg  <= merge(compare_reg, w_data_reg, w_strb_reg);
            timer_ip_reg <= 1'b0;
         end
         if (count_reg == compare_reg) begin
            timer_ip_reg <= 1'b1;  // [RL1]
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         sw_ip_reg <= 2'h0;
      end else if (wr_go && aw_addr_reg == ADDR_CAUSE && w_strb_reg[1]) begin
         sw_ip_reg <= w_data_reg[CAUSE_IP_LSB +: 2] & SW_IP_MASK;  // [RL3]
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Exception capture
   assign resume_upd = EXC_COMMIT && !exl_reg;  // [RL9]
   assign ret_addr = ret_fmt(EXC_IN_SLOT ? EXC_PREV_PC : EXC_PC, EXC_ISA16,
                             isa16_reg, EXC_MODE64);  // [RL5] [RL7]

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         resume_reg <= 64'h0000_0000_0000_0000;
         bd_reg     <= 1'b0;
         code_reg   <= 5'h00;
      end else begin
         if (wr_go && aw_addr_reg == ADDR_RESUME_LO) begin
            resume_reg[31:0] <= merge(resume_reg[31:0], w_data_reg, w_strb_reg);  // [RL4]
         end
         if (wr_go && aw_addr_reg == ADDR_RESUME_HI) begin
            resume_reg[63:32] <= merge(resume_reg[63:32], w_data_reg, w_strb_reg);
         end
         if (EXC_COMMIT) begin
            code_reg <= WATCH_EXC ? CODE_WATCH : EXC_CODE;  // [RL10] [RL25]
            bd_reg   <= EXC_IN_SLOT;  // [RL23]
         end
         if (resume_upd) begin
            resume_reg <= ret_addr;  // [RL4] [RL25]
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         exl_reg <= 1'b0;
         erl_reg <= 1'b1;  // [RL24]
         bev_reg <= 1'b1;  // [RL24]
      end else begin
         if (wr_go && aw_addr_reg == ADDR_STATUS) begin
            exl_reg <= w_data_reg[STAT_EXL_BIT];
            erl_reg <= w_data_reg[STAT_ERL_BIT];
            bev_reg <= w_data_reg[STAT_BEV_BIT];
         end
         if (EXL_CLEAR) begin
            exl_reg <= 1'b0;
         end
         if (ERR_CLEAR) begin
            erl_reg <= 1'b0;
         end
         if (EXC_COMMIT) begin
            exl_reg <= 1'b1;  // [RL9]
         end
         if (ERR_EVENT) begin
            erl_reg <= 1'b1;
         end
      end
   end

   assign EXCEPTION_LEVEL         = exl_reg;
   assign ERROR_LEVEL             = erl_reg;
   assign BOOTSTRAP_VECTOR_SELECT = bev_reg;

   // Error PC: no delay flag, but slot still yields branch address
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         err_resume_reg <= 64'h0000_0000_0000_0000;
      end else begin
         if (wr_go && aw_addr_reg == ADDR_ERR_LO) begin
            err_resume_reg[31:0] <= merge(err_resume_reg[31:0], w_data_reg, w_strb_reg);
         end
         if (wr_go && aw_addr_reg == ADDR_ERR_HI) begin
            err_resume_reg[63:32] <= merge(err_resume_reg[63:32], w_data_reg, w_strb_reg);
         end
         if (ERR_EVENT && !erl_reg) begin  // [RL21]
            err_resume_reg <= ret_addr;  // [RL20] [RL22]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Watch; contents need software setup after reset
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         watch_lo_reg <= 32'h0000_0000;  // [RL13]
         watch_hi_reg <= 32'h0000_0000;
      end else begin
         if (wr_go && aw_addr_reg == ADDR_WATCH_LO) begin
            watch_lo_reg <= merge(watch_lo_reg, w_data_reg, w_strb_reg) & 32'hFFFF_FFFB;
         end
         if (wr_go && aw_addr_reg == ADDR_WATCH_HI) begin
            watch_hi_reg <= merge(watch_hi_reg, w_data_reg, w_strb_reg);
         end
      end
   end

   cp0_watch_match u_watch (
      .access_valid       (ACC_VALID),
      .access_is_store    (ACC_STORE),
      .access_aborted     (ACC_ABORTED),
      .access_paddr       (ACC_PADDR),
      .watch_phys_addr    (watch_lo_reg[31:3]),
      .load_match_enable  (watch_lo_reg[WATCH_R_BIT]),
      .store_match_enable (watch_lo_reg[WATCH_W_BIT]),
      .watch_hit          (watch_hit)
   );
   assign WATCH_EXC = watch_hit;  // [RL10]

   ////////////////////////////////////////////////////////////////////////////////
   // Extended context and compatibility registers
   assign xctx_hi_wr = merge({ptbase_reg, 3'h0}, w_data_reg, w_strb_reg);
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         ptbase_reg <= 29'h0000000;
         space_reg  <= 2'h0;
         vpn2_reg   <= 29'h0000000;
      end else begin
         if (wr_go && aw_addr_reg == ADDR_XCTX_HI) begin
            ptbase_reg <= xctx_hi_wr[31:3];  // [RL16]
         end
         if (TLB_MISS) begin
            vpn2_reg  <= MISS_VADDR[39:11];  // [RL14]
            space_reg <= MISS_VADDR[63:62];  // [RL15]
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         parity_reg    <= 8'h00;
         cache_err_reg <= 32'h0000_0000;
      end else begin
         if (wr_go && aw_addr_reg == ADDR_PARITY && w_strb_reg[0]) begin
            parity_reg <= w_data_reg[7:0] & PARITY_MASK_W;  // [RL18]
         end
         if (wr_go && aw_addr_reg == ADDR_CACHE_ERR) begin
            cache_err_reg <= merge(cache_err_reg, w_data_reg, w_strb_reg);  // [RL19]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_commit;
      EXC_COMMIT && !exl_reg;
   endsequence

   a_resume_capture: assert property (@(posedge CLK) disable iff (!RST_N)
      s_commit |=> resume_reg == $past(ret_addr))  // [RL4]
      else $error("resume_pc not captured");
   a_resume_hold: assert property (@(posedge CLK) disable iff (!RST_N)
      (EXC_COMMIT && exl_reg && !wr_go) |=> $stable(resume_reg))  // [RL9]
      else $error("resume_pc overwritten at exception level");
   a_exl_set: assert property (@(posedge CLK) disable iff (!RST_N)
      EXC_COMMIT |=> exl_reg)  // [RL9]
      else $error("exception level not set");
   a_bd_flag: assert property (@(posedge CLK) disable iff (!RST_N)
      EXC_COMMIT |=> bd_reg == $past(EXC_IN_SLOT))  // [RL23]
      else $error("delay slot flag wrong");
   a_timer_set: assert property (@(posedge CLK) disable iff (!RST_N)
      count_reg == compare_reg |=> INT_PENDING[7])  // [RL1]
      else $error("timer pending not set");
   a_int_follow: assert property (@(posedge CLK) disable iff (!RST_N)
      INT_PENDING[6:2] == INT_REQ)  // [RL2]
      else $error("pending bits not following inputs");
   a_watch_code: assert property (@(posedge CLK) disable iff (!RST_N)
      (EXC_COMMIT && WATCH_EXC) |=> code_reg == CODE_WATCH)  // [RL10]
      else $error("watch code not recorded");
   a_watch_abort: assert property (@(posedge CLK) disable iff (!RST_N)
      ACC_ABORTED |-> !WATCH_EXC)  // [RL26]
      else $error("watch raised on aborted access");
   a_err_hold: assert property (@(posedge CLK) disable iff (!RST_N)
      (erl_reg && !wr_go) |=> $stable(err_resume_reg))  // [RL21]
      else $error("error PC changed at error level");
   a_miss_ctx: assert property (@(posedge CLK) disable iff (!RST_N)
      TLB_MISS |=> vpn2_reg == $past(MISS_VADDR[39:11])
                   && space_reg == $past(MISS_VADDR[63:62]))  // [RL14]
      else $error("extended context not loaded");
endmodule : cp0_exception_state_regs

/* cp0_watch_match.sv */
`timescale 1ns/10ps
module cp0_watch_match
   import cp0_exc_pkg::*;
(
   // Access
   input  wire logic        access_valid,
   input  wire logic        access_is_store,
   input  wire logic        access_aborted,
   input  wire logic [31:0] access_paddr,
   // Watch setup
   input  wire logic [31:3] watch_phys_addr,
   input  wire logic        load_match_enable,
   input  wire logic        store_match_enable,
   // Result
   output logic             watch_hit
);
   logic addr_eq;
   assign addr_eq = (access_paddr[31:3] == watch_phys_addr);  // [RL11]
   // Higher-priority abort wins so one exception per instruction
   assign watch_hit = access_valid && !access_aborted && addr_eq  // [RL26]
                      && (access_is_store ? store_match_enable : load_match_enable); // [RL12]
endmodule : cp0_watch_match

/* test_cp0_exception_state_regs.sv */
`timescale 1ns/10ps
module test_cp0_exception_state_regs
   import cp0_exc_pkg::*;
;
   localparam logic [63:0] VA = 64'hC000_00AB_CDEF_1C00;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        strap = 1'b0;
   logic [4:0]  int_req = 5'h15;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        awvalid = 1'b0;
   logic        wvalid = 1'b0;
   logic        arvalid = 1'b0;
   logic        m64 = 1'b1;
   logic        awready, wready, bvalid, arready, rvalid, watch, exc_lvl, err_lvl, boot_vec;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata, paddr;
   logic [7:0]  int_pend;
   logic [4:0]  kind, code;
   logic [63:0] pc, prev_pc;
   logic        in_slot, isa16;
   logic [2:0]  acc;
   int          fails = 0;
   int          tests_run = 0;

   always #5 clk = ~clk;

   cp0_exception_state_regs cp0_exception_state_regs_inst (
      .CLK(clk), .RST_N(rst_n), .COMPRESSED_ISA_ENABLE(strap), .INT_REQ(int_req),
      .EXC_COMMIT(kind[4]), .EXC_CODE(code), .EXC_PC(pc), .EXC_PREV_PC(prev_pc),
      .EXC_IN_SLOT(in_slot), .EXC_ISA16(isa16), .EXC_MODE64(m64), .TLB_MISS(kind[2]),
      .MISS_VADDR(pc), .ERR_EVENT(kind[3]), .ERR_CLEAR(kind[0]), .EXL_CLEAR(kind[1]),
      .ACC_VALID(acc[2]), .ACC_STORE(acc[1]), .ACC_ABORTED(acc[0]), .ACC_PADDR(paddr),
      .WATCH_EXC(watch), .INT_PENDING(int_pend), .EXCEPTION_LEVEL(exc_lvl),
      .ERROR_LEVEL(err_lvl), .BOOTSTRAP_VECTOR_SELECT(boot_vec),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
      .S_AXI_BREADY(1'b1), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rvalid), .S_AXI_RREADY(1'b1)
   );

   core_pipe core_pipe_inst (
      .clk(clk), .watch_exc(watch), .kind(kind), .code(code), .pc(pc), .prev_pc(prev_pc),
      .in_slot(in_slot), .isa16(isa16), .acc(acc), .paddr(paddr)
   );

   ////////////////////////////////////////////////////////////
   // Handshakes are judged at the falling edge, where nothing moves
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ta;
      logic tw;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      ta = 1'b0;
      tw = 1'b0;
      while (!(ta && tw)) begin
         @(negedge clk);
         ta = ta | (awvalid & awready);
         tw = tw | (wvalid & wready);
         @(posedge clk);
         if (ta)
            awvalid <= 1'b0;
         if (tw)
            wvalid <= 1'b0;
      end
      do @(negedge clk); while (bvalid !== 1'b1);
      @(posedge clk);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      do @(negedge clk); while (arready !== 1'b1);
      @(posedge clk);
      arvalid <= 1'b0;
      do @(negedge clk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      @(posedge clk);
   endtask : rd

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
      logic [31:0] d;
      logic [1:0]  r;
      rd(a, d, r);
      chk(n, e, d);
   endtask : rc

   task automatic give_verdict;
      $display("Checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict

   ////////////////////////////////////////////////////////////
   // Whole run is well under a thousand cycles
   initial begin
      #100000;
      fails++;
      give_verdict();
   end

   initial begin
      logic [31:0] c;
      logic [1:0]  r;
      logic        h;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      rc(ADDR_STATUS, 32'h0040_0004, "status");
      chk("levels", 32'h6, {29'h0, boot_vec, err_lvl, exc_lvl});
      rc(ADDR_CAUSE, 32'h0000_5400, "cause_int");
      int_req <= 5'h0A;
      @(negedge clk);
      chk("int_live", 32'h28, {24'h0, int_pend});
      wr(ADDR_CAUSE, 32'hFFFF_FFFF);
      rc(ADDR_CAUSE, 32'h0000_2B00, "sw_int");
      rd(ADDR_COUNT, c, r);
      wr(ADDR_COMPARE, c + 32'h40);
      repeat (80) @(negedge clk);
      chk("timer", 32'h1, {31'h0, int_pend[7]});
      $display("interrupt tests done");
      core_pipe_inst.pulse(5'h10, 5'h04, 64'hFFFF_FFFF_8000_1000, 64'h0, 1'b0, 1'b0);
      rc(ADDR_RESUME_LO, 32'h8000_1000, "resume_lo");
      rc(ADDR_RESUME_HI, 32'hFFFF_FFFF, "resume_hi");
      rc(ADDR_CAUSE, 32'h0000_AB10, "code");
      chk("exc_lvl", 32'h1, {31'h0, exc_lvl});
      wr(ADDR_ERR_LO, 32'h1111_1110);
      core_pipe_inst.pulse(5'h08, 5'h00, 64'h4000, 64'h3FFC, 1'b1, 1'b0);
      rc(ADDR_ERR_LO, 32'h1111_1110, "err_held");
      core_pipe_inst.pulse(5'h01, 5'h00, 64'h0, 64'h0, 1'b0, 1'b0);
      core_pipe_inst.pulse(5'h08, 5'h00, 64'h5000, 64'h4FFC, 1'b1, 1'b0);
      rc(ADDR_ERR_LO, 32'h0000_4FFC, "err_pc");
      rc(ADDR_CAUSE, 32'h0000_AB10, "err_no_slot");
      core_pipe_inst.pulse(5'h10, 5'h05, 64'h2000, 64'h1FFC, 1'b1, 1'b0);
      rc(ADDR_RESUME_LO, 32'h8000_1000, "resume_held");
      core_pipe_inst.pulse(5'h02, 5'h00, 64'h0, 64'h0, 1'b0, 1'b0);
      core_pipe_inst.pulse(5'h10, 5'h17, 64'h3000, 64'h2FFC, 1'b1, 1'b0);
      rc(ADDR_RESUME_LO, 32'h0000_2FFC, "resume_slot");
      rc(ADDR_CAUSE, 32'h8000_AB5C, "slot_code");
      $display("exception tests done");
      wr(ADDR_WATCH_LO, 32'h0000_123A);
      rc(ADDR_WATCH_LO, 32'h0000_123A, "watch_lo");
      core_pipe_inst.access(32'h0000_123C, 3'h4, h);
      chk("load_hit", 32'h1, {31'h0, h});
      core_pipe_inst.access(32'h0000_123C, 3'h6, h);
      chk("store_off", 32'h0, {31'h0, h});
      core_pipe_inst.access(32'h0000_1240, 3'h4, h);
      chk("next_dword", 32'h0, {31'h0, h});
      core_pipe_inst.access(32'h0000_123C, 3'h5, h);
      chk("aborted", 32'h0, {31'h0, h});
      fork
         core_pipe_inst.access(32'h0000_123C, 3'h4, h);
         core_pipe_inst.pulse(5'h10, 5'h00, 64'h0, 64'h0, 1'b0, 1'b0);
      join
      rc(ADDR_CAUSE, 32'h0000_AB5C, "watch_code");
      $display("watch tests done");
      wr(ADDR_XCTX_HI, 32'hFFFF_FFF8);
      core_pipe_inst.pulse(5'h04, 5'h00, VA, 64'h0, 1'b0, 1'b0);
      rc(ADDR_XCTX_LO, {VA[38:11], 4'h0}, "vpage");
      rc(ADDR_XCTX_HI, {29'h1FFF_FFFF, VA[63:62], VA[39]}, "space");
      wr(ADDR_PARITY, 32'hFFFF_FFFF);
      rc(ADDR_PARITY, 32'h0000_00FF, "parity");
      wr(ADDR_CACHE_ERR, 32'hA5A5_5A5A);
      rc(ADDR_CACHE_ERR, 32'hA5A5_5A5A, "cache_err");
      rd(8'h38, c, r);
      chk("unmapped", {30'h0, RESP_SLVERR}, {30'h0, r});
      $display("register tests done");
      rst_n <= 1'b0;
      strap <= 1'b1;
      m64 <= 1'b0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      rc(ADDR_STATUS, 32'h0040_0005, "strap");
      core_pipe_inst.pulse(5'h10, 5'h04, 64'h6000, 64'h8000_5FFE, 1'b1, 1'b1);
      rc(ADDR_RESUME_LO, 32'h8000_5FFF, "isa16_slot");
      rc(ADDR_RESUME_HI, 32'hFFFF_FFFF, "isa16_hi");
      $display("compressed tests done");
      give_verdict();
   end
endmodule : test_cp0_exception_state_regs
